// *** hw/tcr_config_ram.sv ***
// transceiver configuration ram: data buffer, control and status registers
// reached over the 4-wire serial port; receiver logic shares the core clock
`timescale 1ns/100ps
module tcr_config_ram (
    input  wire logic                      clk_i,
    input  wire logic                      arst_n_i,
    input  wire tcr_pkg::tcr_spi_s         spi_i,
    output logic                           sdo_o,
    output logic                           sdo_oe_o,
    input  wire logic                      power_up_pin_i,
    input  wire logic [tcr_pkg::BTN_NUM-1:0] push_button_n_i,
    input  wire logic                      supply_low_i,
    input  wire logic                      aux_switched_i,
    input  wire logic                      aux_turn_on_i,
    input  wire logic                      supply_off_i,
    input  wire logic                      rx_mode_i,
    input  wire logic                      rx_byte_valid_i,
    input  wire logic [tcr_pkg::DATA_W-1:0] rx_byte_i,
    input  wire logic                      rx_error_i,
    input  wire logic [tcr_pkg::BUF_AW-1:0] buf_rd_addr_i,
    output logic      [tcr_pkg::DATA_W-1:0] buf_rd_data_o,
    output tcr_pkg::tcr_cfg_s              cfg_o,
    output logic                           powered_o,
    output logic                           irq_o
);
    import tcr_pkg::*;

    // eight single-bit pins plus the buttons; edge pins keep a third stage
    localparam int unsigned SYNC_W = BTN_NUM + 8;
    localparam int unsigned EDGE_W = BTN_NUM + 3;

    logic [SYNC_W-1:0] pins_async;
    logic [SYNC_W-1:0] pins_idle;
    logic [SYNC_W-1:0] pins_s;
    logic [EDGE_W-1:0] pins_q_reg;

    logic               cs_n_s;
    logic               sck_s;
    logic               sdi_s;
    logic               pwr_s;
    logic [BTN_NUM-1:0] btn_n_s;
    logic               low_s;
    logic               auxsw_s;
    logic               auxon_s;
    logic               off_s;
    logic               sck_q;
    logic               pwr_q;
    logic [BTN_NUM-1:0] btn_n_q;
    logic               auxon_q;

    assign pins_async = {spi_i.cs_n, spi_i.sck, spi_i.sdi, power_up_pin_i,
                         push_button_n_i, supply_low_i, aux_switched_i,
                         aux_turn_on_i, supply_off_i};
    // idle levels: deselected, buttons released, supply present
    assign pins_idle  = {1'b1, 1'b0, 1'b0, 1'b0, {BTN_NUM{1'b1}},
                         1'b0, 1'b0, 1'b0, 1'b0};

    tcr_sync #(
        .WIDTH     (SYNC_W)
    ) u_sync (
        .clk_i     (clk_i),
        .arst_n_i  (arst_n_i),
        .async_i   (pins_async),
        .rst_val_i (pins_idle),
        .sync_o    (pins_s)
    );

    assign {cs_n_s, sck_s, sdi_s, pwr_s, btn_n_s, low_s, auxsw_s,
            auxon_s, off_s} = pins_s;
    assign {sck_q, pwr_q, btn_n_q, auxon_q} = pins_q_reg;

    logic sck_rise;
    logic sck_fall;
    logic turn_on_evt;

    assign sck_rise    = sck_s & ~sck_q & ~cs_n_s;
    assign sck_fall    = ~sck_s & sck_q & ~cs_n_s;
    assign turn_on_evt = (pwr_s & ~pwr_q) | (|(~btn_n_s & btn_n_q)) |
                         (auxon_s & ~auxon_q);

    // state
    logic                            powered_reg,  powered_next;
    logic [CNT_W-1:0]                bit_cnt_reg,  bit_cnt_next;
    logic [DATA_W-1:0]               shift_reg,    shift_next;
    logic [DATA_W-1:0]               cmd_reg,      cmd_next;
    logic [DATA_W-1:0]               out_reg,      out_next;
    logic [CTRL_NUM-1:0][DATA_W-1:0] ctrl_reg,     ctrl_next;
    logic                            low_batt_reg, low_batt_next;
    logic                            aux_flag_reg, aux_flag_next;
    logic                            rx_err_reg,   rx_err_next;
    logic [CNT_W-1:0]                rx_cnt_reg,   rx_cnt_next;
    logic                            irq_reg,      irq_next;
    logic [DATA_W-1:0]               rd_data_reg,  rd_data_next;

    logic [DATA_W-1:0] buf_mem [BUF_DEPTH];
    logic              buf_we;
    logic [BUF_AW-1:0] buf_waddr;
    logic [DATA_W-1:0] buf_wdata;

    logic [DATA_W-1:0] status_byte;
    logic [DATA_W-1:0] rd_mux;
    logic [ADDR_W-1:0] cur_addr;
    logic [ADDR_W-1:0] cmd_addr;
    logic [DATA_W-1:0] wr_byte;
    logic              host_wr;
    logic              status_rd_done;
    logic              rx_wr;
    tcr_cfg_s          cfg;
    logic [CNT_W-1:0]  irq_thr;

    assign cfg = tcr_cfg_s'({ctrl_reg[5], ctrl_reg[4], ctrl_reg[3],
                             ctrl_reg[2], ctrl_reg[1], ctrl_reg[0]});

    // status is assembled live, never stored in the ram
    assign status_byte = {~btn_n_s, pwr_s, low_batt_reg,
                          aux_flag_reg};

    // read address: the command byte as its last bit arrives; taken from
    // wr_byte so the read mux does not feed back into the framing process
    assign cur_addr = wr_byte[ADDR_W-1:0];
    assign cmd_addr = cmd_reg[ADDR_W-1:0];
    assign wr_byte  = {shift_reg[DATA_W-2:0], sdi_s};

    always_comb begin
        rd_mux = '0;
        if (cur_addr <= ADR_CTRL_SIX) begin
            rd_mux = ctrl_reg[cur_addr[2:0]];
        end else if (cur_addr == ADR_STATUS) begin
            rd_mux = status_byte;
        end else if (cur_addr[ADR_BUF_BIT]) begin
            rd_mux = buf_mem[cur_addr[BUF_AW-1:0]];
        end
    end

    // serial framing: command byte then one data byte, msb first,
    // sampled on sck rising, sdo shifted on sck falling
    always_comb begin
        bit_cnt_next   = bit_cnt_reg;
        shift_next     = shift_reg;
        cmd_next       = cmd_reg;
        out_next       = out_reg;
        host_wr        = 1'b0;
        status_rd_done = 1'b0;
        if (cs_n_s || !powered_reg) begin
            bit_cnt_next = '0;
            out_next     = '0;
        end else if (sck_rise && bit_cnt_reg < BIT_FRAME_END) begin
            shift_next   = wr_byte;
            bit_cnt_next = bit_cnt_reg + 5'h01;
            if (bit_cnt_next == BIT_CMD_END) begin
                cmd_next = wr_byte;
                if (wr_byte[CMD_RD_BIT]) begin
                    out_next = rd_mux;
                end
            end else if (bit_cnt_next == BIT_FRAME_END) begin
                host_wr        = ~cmd_reg[CMD_RD_BIT];
                status_rd_done = cmd_reg[CMD_RD_BIT] &
                                 (cmd_addr == ADR_STATUS);
            end
        end else if (sck_fall && bit_cnt_reg > BIT_CMD_END) begin
            out_next = {out_reg[DATA_W-2:0], 1'b0};
        end
    end

    // control registers, reserved bits held at zero
    always_comb begin
        ctrl_next = ctrl_reg;
        if (off_s || (!powered_reg && turn_on_evt)) begin
            ctrl_next[0] = CTRL_ONE_RST;
            for (int i = 1; i < CTRL_NUM; i++) begin
                ctrl_next[i] = CTRL_OTHER_RST;
            end
        end else if (host_wr) begin
            if (cmd_addr == ADR_CTRL_ONE) begin
                ctrl_next[0] = wr_byte & CTRL_ONE_WMASK;
            end else if (cmd_addr == ADR_CTRL_TWO) begin
                ctrl_next[1] = wr_byte & CTRL_ALL_WMASK;
            end else if (cmd_addr == ADR_CTRL_THREE) begin
                ctrl_next[2] = wr_byte & CTRL_THR_WMASK;
            end else if (cmd_addr == ADR_CTRL_FOUR) begin
                ctrl_next[3] = wr_byte & CTRL_ALL_WMASK;
            end else if (cmd_addr == ADR_CTRL_FIVE) begin
                ctrl_next[4] = wr_byte & CTRL_ALL_WMASK;
            end else if (cmd_addr == ADR_CTRL_SIX) begin
                ctrl_next[5] = wr_byte & CTRL_ALL_WMASK;
            end
        end
    end

    // power state and status flags
    always_comb begin
        powered_next  = powered_reg;
        low_batt_next = low_batt_reg;
        aux_flag_next = auxsw_s;
        if (off_s) begin
            powered_next  = 1'b0;
            low_batt_next = 1'b0;
            aux_flag_next = 1'b0;
        end else begin
            if (!powered_reg && turn_on_evt) begin
                powered_next = 1'b1;
            end
            // a new low reading wins over a clearing read
            if (low_s) begin
                low_batt_next = 1'b1;
            end else if (status_rd_done) begin
                low_batt_next = 1'b0;
            end
        end
    end

    // receive byte counting and the buffer write port
    assign rx_wr = rx_mode_i & rx_byte_valid_i & powered_reg &
                   (rx_cnt_reg < RX_CNT_FULL);

    always_comb begin
        rx_cnt_next = rx_cnt_reg;
        rx_err_next = rx_err_reg;
        if (off_s || !rx_mode_i) begin
            rx_cnt_next = '0;
            rx_err_next = 1'b0;
        end else begin
            if (rx_wr) begin
                rx_cnt_next = rx_cnt_reg + 5'h01;
            end
            if (rx_error_i) begin
                rx_err_next = 1'b1;
            end
        end
    end

    // receiver owns the buffer while it writes; a colliding host write
    // is dropped since the host should not fill the buffer in receive
    always_comb begin
        buf_we    = 1'b0;
        buf_waddr = '0;
        buf_wdata = '0;
        if (rx_wr) begin
            buf_we    = 1'b1;
            buf_waddr = rx_cnt_reg[BUF_AW-1:0];
            buf_wdata = rx_byte_i;
        end else if (host_wr && cmd_addr[ADR_BUF_BIT]) begin
            buf_we    = 1'b1;
            buf_waddr = cmd_addr[BUF_AW-1:0];
            buf_wdata = wr_byte;
        end
    end

    // receive interrupt level
    always_comb begin
        case (cfg.irq_level_sel)
            IRQ_SEL_4:  irq_thr = IRQ_CNT_4;
            IRQ_SEL_8:  irq_thr = IRQ_CNT_8;
            IRQ_SEL_12: irq_thr = IRQ_CNT_12;
            default:    irq_thr = IRQ_CNT_12;
        endcase
        irq_next = rx_mode_i & powered_reg &
                   (rx_err_next |
                    ((cfg.irq_level_sel != IRQ_SEL_ERR) &
                     (rx_cnt_next >= irq_thr)));
        rd_data_next = buf_mem[buf_rd_addr_i];
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pins_q_reg   <= '0;
            powered_reg  <= 1'b1;
            bit_cnt_reg  <= '0;
            shift_reg    <= '0;
            cmd_reg      <= '0;
            out_reg      <= '0;
            ctrl_reg[0]  <= CTRL_ONE_RST;
            for (int i = 1; i < CTRL_NUM; i++) begin
                ctrl_reg[i] <= CTRL_OTHER_RST;
            end
            low_batt_reg <= 1'b0;
            aux_flag_reg <= 1'b0;
            rx_err_reg   <= 1'b0;
            rx_cnt_reg   <= '0;
            irq_reg      <= 1'b0;
            rd_data_reg  <= '0;
        end else begin
            pins_q_reg   <= {sck_s, pwr_s, btn_n_s, auxon_s};
            powered_reg  <= powered_next;
            bit_cnt_reg  <= bit_cnt_next;
            shift_reg    <= shift_next;
            cmd_reg      <= cmd_next;
            out_reg      <= out_next;
            ctrl_reg     <= ctrl_next;
            low_batt_reg <= low_batt_next;
            aux_flag_reg <= aux_flag_next;
            rx_err_reg   <= rx_err_next;
            rx_cnt_reg   <= rx_cnt_next;
            irq_reg      <= irq_next;
            rd_data_reg  <= rd_data_next;
        end
    end

    // buffer has no reset; loss of supply wipes it to zero
    always_ff @(posedge clk_i) begin
        if (off_s) begin
            for (int i = 0; i < BUF_DEPTH; i++) begin
                buf_mem[i] <= '0;
            end
        end else if (buf_we) begin
            buf_mem[buf_waddr] <= buf_wdata;
        end
    end

    logic sdo_oe;
    assign sdo_oe = ~cs_n_s & powered_reg & cmd_reg[CMD_RD_BIT] &
                    (bit_cnt_reg >= BIT_CMD_END);

    assign sdo_o         = out_reg[DATA_W-1];
    assign sdo_oe_o      = sdo_oe;
    assign buf_rd_data_o = rd_data_reg;
    assign cfg_o         = cfg;
    assign powered_o     = powered_reg;
    assign irq_o         = irq_reg;

endmodule : tcr_config_ram

// *** hw/tcr_pkg.sv ***
// constants, field layouts and carrier types of the transceiver config ram
// assumes a single 250 MHz core clock; serial pins arrive asynchronously
package tcr_pkg;

    localparam int unsigned DATA_W    = 8;
    localparam int unsigned BUF_DEPTH = 16;
    localparam int unsigned BUF_AW    = 4;
    localparam int unsigned CTRL_NUM  = 6;
    localparam int unsigned ADDR_W    = 5;
    localparam int unsigned CNT_W     = 5;
    localparam int unsigned BTN_NUM   = 5;

    // serial addresses
    localparam logic [ADDR_W-1:0] ADR_CTRL_ONE   = 5'h00;
    localparam logic [ADDR_W-1:0] ADR_CTRL_TWO   = 5'h01;
    localparam logic [ADDR_W-1:0] ADR_CTRL_THREE = 5'h02;
    localparam logic [ADDR_W-1:0] ADR_CTRL_FOUR  = 5'h03;
    localparam logic [ADDR_W-1:0] ADR_CTRL_FIVE  = 5'h04;
    localparam logic [ADDR_W-1:0] ADR_CTRL_SIX   = 5'h05;
    localparam logic [ADDR_W-1:0] ADR_STATUS     = 5'h08;
    localparam logic [ADDR_W-1:0] ADR_BUF_BASE   = 5'h10;
    localparam int unsigned       ADR_BUF_BIT    = 4;

    // command byte: read flag and address field
    localparam int unsigned       CMD_RD_BIT     = 7;
    localparam logic [CNT_W-1:0]  BIT_CMD_END    = 5'h08;
    localparam logic [CNT_W-1:0]  BIT_FRAME_END  = 5'h10;

    // receive interrupt threshold codes and byte counts
    localparam logic [1:0]        IRQ_SEL_4      = 2'h0;
    localparam logic [1:0]        IRQ_SEL_8      = 2'h1;
    localparam logic [1:0]        IRQ_SEL_12     = 2'h2;
    localparam logic [1:0]        IRQ_SEL_ERR    = 2'h3;
    localparam logic [CNT_W-1:0]  IRQ_CNT_4      = 5'h04;
    localparam logic [CNT_W-1:0]  IRQ_CNT_8      = 5'h08;
    localparam logic [CNT_W-1:0]  IRQ_CNT_12     = 5'h0c;
    localparam logic [CNT_W-1:0]  RX_CNT_FULL    = 5'h10;

    // control register defaults and writable bits
    localparam logic [DATA_W-1:0] CTRL_ONE_RST   = 8'h80;
    localparam logic [DATA_W-1:0] CTRL_OTHER_RST = 8'h00;
    localparam logic [DATA_W-1:0] CTRL_ONE_WMASK = 8'hf7;
    localparam logic [DATA_W-1:0] CTRL_THR_WMASK = 8'h0f;
    localparam logic [DATA_W-1:0] CTRL_ALL_WMASK = 8'hff;

    // status register layout
    localparam int unsigned       ST_BTN_LSB     = 3;
    localparam int unsigned       ST_PWR_BIT     = 2;
    localparam int unsigned       ST_LOWBAT_BIT  = 1;
    localparam int unsigned       ST_AUX_BIT     = 0;

    typedef struct packed {
        logic       cs_n;
        logic       sck;
        logic       sdi;
    } tcr_spi_s;

    // first field is control_six, last is control_one
    typedef struct packed {
        logic [1:0] rate_range;
        logic [5:0] upper_period_limit;
        logic [1:0] bit_check_count;
        logic [5:0] lower_period_limit;
        logic       keying_select;
        logic [4:0] sleep_time;
        logic       sleep_extension;
        logic       limit_extension;
        logic [3:0] unused_three;
        logic [1:0] freq_word_hi;
        logic       supply_out_enable;
        logic       clock_out_enable;
        logic [6:0] freq_word_lo;
        logic       polling_mode;
        logic [1:0] irq_level_sel;
        logic       analog_supply_enable;
        logic       freq_band_select;
        logic       unused_one;
        logic [1:0] op_mode;
        logic       transmit_mode;
    } tcr_cfg_s;

endpackage : tcr_pkg

// *** hw/tcr_sync.sv ***
// two flip-flop synchroniser for a bundle of asynchronous levels
// assumes each bit changes slowly compared with the core clock
`timescale 1ns/100ps
module tcr_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             arst_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    input  wire logic [WIDTH-1:0] rst_val_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_next;
    logic             seeded_reg;
    logic             seeded_next;

    // reset value is a constant; the idle level is loaded after release
    always_comb begin
        meta_next   = async_i;
        sync_next   = seeded_reg ? meta_reg : rst_val_i;
        seeded_next = 1'b1;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_reg   <= '0;
            sync_reg   <= '0;
            seeded_reg <= 1'b0;
        end else begin
            meta_reg   <= meta_next;
            sync_reg   <= sync_next;
            seeded_reg <= seeded_next;
        end
    end

    assign sync_o = sync_reg;

endmodule : tcr_sync

// *** testbench/tcr_config_ram_asserts.sv ***
// port checker of the config ram: receive irq, power state, reserved bits
// assumes it is bound into tcr_config_ram and sees only its ports
`timescale 1ns/100ps
module tcr_config_ram_asserts (
    input wire logic              clk_i,
    input wire logic              arst_n_i,
    input wire tcr_pkg::tcr_spi_s spi_i,
    input wire logic              sdo_oe_o,
    input wire logic              supply_off_i,
    input wire logic              rx_mode_i,
    input wire logic              rx_error_i,
    input wire tcr_pkg::tcr_cfg_s cfg_o,
    input wire logic              powered_o,
    input wire logic              irq_o
);
    import tcr_pkg::*;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);

    // pins pass two sync stages, so allow a few cycles of lag
    sequence s_off_held;
        supply_off_i [*3];
    endsequence
    sequence s_cs_idle;
        spi_i.cs_n [*4];
    endsequence

    property p_irq_err;
        rx_mode_i && rx_error_i |=> irq_o;
    endproperty
    a_irq_err: assert property (p_irq_err)
        else $error("irq missing after receive error");
    property p_irq_off;
        !rx_mode_i |=> !irq_o;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("irq high outside receive mode");
    property p_sel_err_only;
        rx_mode_i && !rx_error_i && !irq_o
            && cfg_o.irq_level_sel == IRQ_SEL_ERR |=> !irq_o;
    endproperty
    a_sel_err_only: assert property (p_sel_err_only)
        else $error("irq raised by byte count with code 11");
    property p_irq_cause;
        $rose(irq_o) |-> $past(rx_mode_i);
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("irq rose without receive mode");
    property p_irq_hold;
        irq_o && rx_mode_i && $stable(cfg_o.irq_level_sel) |=> irq_o;
    endproperty
    a_irq_hold: assert property (p_irq_hold)
        else $error("irq dropped while still in receive mode");
    property p_off;
        s_off_held |-> ##[0:4] !powered_o;
    endproperty
    a_off: assert property (p_off)
        else $error("device stayed active with supply removed");
    property p_off_cfg;
        !powered_o ##1 !powered_o |-> cfg_o == {40'h0, CTRL_ONE_RST};
    endproperty
    a_off_cfg: assert property (p_off_cfg)
        else $error("control registers not at defaults while off");
    property p_rsv;
        cfg_o.unused_one == 1'b0 && cfg_o.unused_three == 4'h0;
    endproperty
    a_rsv: assert property (p_rsv)
        else $error("unused control bits not zero");
    property p_oe_idle;
        s_cs_idle |-> !sdo_oe_o;
    endproperty
    a_oe_idle: assert property (p_oe_idle)
        else $error("serial output driven outside a frame");
endmodule : tcr_config_ram_asserts

bind tcr_config_ram tcr_config_ram_asserts tcr_config_ram_asserts_i (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .spi_i(spi_i), .sdo_oe_o(sdo_oe_o),
    .supply_off_i(supply_off_i), .rx_mode_i(rx_mode_i),
    .rx_error_i(rx_error_i), .cfg_o(cfg_o), .powered_o(powered_o),
    .irq_o(irq_o)
);

// *** testbench/tcr_host_model.sv ***
// host side of the 4-wire serial port: drives frames, collects read data
// assumes clk_i is the 4 ns core clock; serial clock is 16 core cycles
`timescale 1ns/100ps
module tcr_host_model (
    input  wire logic        clk_i,
    input  wire logic        sdo_i,
    input  wire logic        sdo_oe_i,
    output tcr_pkg::tcr_spi_s spi_o
);
    import tcr_pkg::*;
    localparam int HALF = 8;

    initial begin
        spi_o = '{cs_n: 1'b1, sck: 1'b0, sdi: 1'b0};
    end

    task automatic half_wait();
        repeat (HALF) @(negedge clk_i);
    endtask : half_wait

    // sck stands low outside frames; an undriven sdo reads as unknown
    task automatic frame(input logic [7:0] cmd, input logic [7:0] wdat,
                         output logic [7:0] rdat);
        logic [15:0] sh;
        sh = {cmd, wdat};
        spi_o.cs_n = 1'b0;
        for (int i = 0; i < 16; i++) begin
            spi_o.sdi = sh[15-i];
            half_wait();
            spi_o.sck = 1'b1;
            if (i >= 8) rdat[15-i] = sdo_oe_i ? sdo_i : 1'bx;
            half_wait();
            spi_o.sck = 1'b0;
        end
        half_wait();
        spi_o.cs_n = 1'b1;
        half_wait();
        half_wait();
    endtask : frame
endmodule : tcr_host_model

// *** testbench/test_tcr_config_ram.sv ***
// self-checking bench of the config ram through its serial port
// assumes tcr_pkg, the design and the host model are compiled first
`timescale 1ns/100ps
module test_tcr_config_ram;
    import tcr_pkg::*;
    logic               clk;
    logic               arst_n;
    tcr_spi_s           spi;
    logic               sdo;
    logic               sdo_oe;
    logic               pwr_pin;
    logic [BTN_NUM-1:0] btn_n;
    logic               sup_low;
    logic               aux_sw;
    logic               aux_on;
    logic               sup_off;
    logic               rx_mode;
    logic               rx_vld;
    logic [7:0]         rx_byte;
    logic               rx_err;
    logic [3:0]         rd_addr;
    logic [7:0]         rd_data;
    tcr_cfg_s           cfg;
    logic               powered;
    logic               irq;
    logic [7:0]         rdat;
    int                 num_errors = 0;
    int                 total_checks = 0;
    int                 cycles = 0;
    logic [4:0] t_adr [8] = '{5'h0, 5'h1, 5'h2, 5'h3, 5'h4, 5'h5, 5'h6, 5'h8};
    logic [7:0] t_wr  [8] = '{8'hff, 8'h22, 8'hff, 8'h44, 8'h55, 8'h66,
                              8'h99, 8'h00};
    logic [7:0] t_exp [8] = '{8'hf7, 8'h22, 8'h0f, 8'h44, 8'h55, 8'h66,
                              8'h00, 8'h00};

    tcr_config_ram tcr_config_ram_i (
        .clk_i(clk), .arst_n_i(arst_n), .spi_i(spi), .sdo_o(sdo),
        .sdo_oe_o(sdo_oe), .power_up_pin_i(pwr_pin), .push_button_n_i(btn_n),
        .supply_low_i(sup_low), .aux_switched_i(aux_sw),
        .aux_turn_on_i(aux_on), .supply_off_i(sup_off), .rx_mode_i(rx_mode),
        .rx_byte_valid_i(rx_vld), .rx_byte_i(rx_byte), .rx_error_i(rx_err),
        .buf_rd_addr_i(rd_addr), .buf_rd_data_o(rd_data), .cfg_o(cfg),
        .powered_o(powered), .irq_o(irq)
    );
    tcr_host_model host_i (
        .clk_i(clk), .sdo_i(sdo), .sdo_oe_i(sdo_oe), .spi_o(spi)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            $display("MISMATCH %0t run did not finish", $time);
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        host_i.frame({3'h0, a}, d, rdat);
    endtask : wr

    task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
        host_i.frame({3'h4, a}, 8'h00, rdat);
        chk(rdat, e);
    endtask : rd_chk

    task automatic buf_chk(input logic [3:0] a, input logic [7:0] e);
        rd_addr = a;
        repeat (2) @(negedge clk);
        chk(rd_data, e);
    endtask : buf_chk

    // count restarts each run because leaving receive mode clears it
    task automatic rx_run(input int thr);
        rx_mode = 1'b1;
        for (int k = 0; k < 16; k++) begin
            rx_vld = 1'b1;
            rx_byte = 8'h40 + 8'(k);
            @(negedge clk);
            rx_vld = 1'b0;
            @(negedge clk);
            chk(irq, (k + 1 >= thr));
        end
        buf_chk(4'h5, 8'h45);
        rx_err = 1'b1;
        @(negedge clk);
        rx_err = 1'b0;
        @(negedge clk);
        chk(irq, 1'b1);
        rx_mode = 1'b0;
        repeat (2) @(negedge clk);
        chk(irq, 1'b0);
    endtask : rx_run

    initial begin
        arst_n = 1'b0;
        {pwr_pin, sup_low, aux_sw, aux_on, sup_off} = 5'h00;
        {rx_mode, rx_vld, rx_err} = 3'h0;
        btn_n = '1;
        rx_byte = 8'h00;
        rd_addr = 4'h0;
        repeat (3) @(negedge clk);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        chk(powered, 1'b1);
        for (int i = 0; i < 6; i++) begin
            rd_chk(5'(i), i == 0 ? 8'h80 : 8'h00);
        end
        $display("test defaults done");
        rx_run(12);
        for (int c = 0; c < 4; c++) begin
            wr(ADR_CTRL_ONE, {2'(c), 6'h00});
            rx_run(c == 3 ? 17 : 4 * (c + 1));
        end
        $display("test receive irq done");
        for (int i = 0; i < 8; i++) wr(t_adr[i], t_wr[i]);
        for (int i = 0; i < 8; i++) begin
            rd_chk(t_adr[i], t_exp[i]);
        end
        chk(cfg, 48'h6655440f22f7);
        $display("test registers done");
        btn_n = 5'b10110;
        {pwr_pin, sup_low, aux_sw} = 3'h7;
        repeat (4) @(negedge clk);
        rd_chk(ADR_STATUS, 8'h4f);
        sup_low = 1'b0;
        rd_chk(ADR_STATUS, 8'h4f);
        rd_chk(ADR_STATUS, 8'h4d);
        btn_n = '1;
        {pwr_pin, aux_sw} = 2'h0;
        $display("test status done");
        wr(5'h13, 8'h3c);
        rd_chk(5'h13, 8'h3c);
        buf_chk(4'h3, 8'h3c);
        $display("test buffer done");
        for (int e = 0; e < 3; e++) begin
            wr(ADR_CTRL_TWO, 8'h5a);
            chk(cfg, e == 0 ? 48'h6655440f5af7 : 48'h5a80);
            sup_off = 1'b1;
            repeat (8) @(negedge clk);
            chk(powered, 1'b0);
            wr(ADR_CTRL_TWO, 8'h77);
            chk(cfg, 48'h80);
            sup_off = 1'b0;
            repeat (4) @(negedge clk);
            btn_n[0] = (e != 0);
            pwr_pin = (e == 1);
            aux_on = (e == 2);
            repeat (8) @(negedge clk);
            chk(powered, 1'b1);
            chk(cfg, 48'h80);
            btn_n = '1;
            {pwr_pin, aux_on} = 2'h0;
            repeat (4) @(negedge clk);
        end
        buf_chk(4'h5, 8'h00);
        $display("test power cycle done");
        stop_test();
    end
endmodule : test_tcr_config_ram
